// ---- hdl/twc_chan_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - One activity lamp per channel, lit while that channel is active.
// - Channel error lamp sets on an I/O error, clears on device select.
// - Console reset clears every channel error lamp too.
// - Show the unit address of the switch-selected channel on six lamps.
// - Read keyboard connects, lights input lamp, packs four characters per word.
// - Type output connects, powers typewriter, unpacks four characters per word.
// - Interlaced output ends itself by clearing the unit address.
// - Channel active test skips only while the unit address is zero.
// - Parity or character rate error sets the channel error flip-flop.
// - Command bit 9 is the interlace alert for word-counted transfer.
// - Output count zero: disconnect after last character, then end-of-record interrupt.
// - Interlaced input disconnects when the word count reaches zero.
// - The typewriter has no ready test and is always ready.
// - Carriage return is code 052 octal, space is 012 octal.
module twc_chan_ctrl
  import twc_pkg::*;
#(
  parameter int TW_CHAN = 0
)
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] bus_addr_i,
  input  wire logic [DATA_W-1:0] bus_wdata_i,
  input  wire logic              bus_we_i,
  input  wire logic              bus_re_i,
  output logic      [DATA_W-1:0] bus_rdata_o,
  output logic                   irq_o,
  input  wire logic [CH_W-1:0]   chan_sel_i,
  input  wire logic              console_reset_i,
  input  wire logic [CHAR_W-1:0] tw_key_i,
  input  wire logic              tw_key_par_i,
  input  wire logic              tw_key_stb_i,
  input  wire logic              tw_done_i,
  output logic      [CHAR_W-1:0] tw_char_o,
  output logic                   tw_char_par_o,
  output logic                   tw_char_stb_o,
  output logic                   tw_input_lamp_o,
  output logic                   tw_power_o,
  output logic      [NUM_CH-1:0] active_lamp_o,
  output logic      [NUM_CH-1:0] error_lamp_o,
  output logic      [UA_W-1:0]   unit_addr_disp_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  localparam int SYNC_W = CH_W + CHAR_W + 4;

  logic [SYNC_W-1:0] meta_r;
  logic [SYNC_W-1:0] sync_r;
  logic              kstb_d_r;
  logic              done_d_r;

  // Key data is sampled with its strobe; the typewriter holds it steady long after.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r   <= '0;
      sync_r   <= '0;
      kstb_d_r <= 1'b0;
      done_d_r <= 1'b0;
    end
    else
    begin
      meta_r   <= {chan_sel_i, console_reset_i, tw_key_i, tw_key_par_i, tw_key_stb_i, tw_done_i};
      sync_r   <= meta_r;
      kstb_d_r <= sync_r[1];
      done_d_r <= sync_r[0];
    end
  end

  logic [CH_W-1:0]   sel_s;
  logic              creset_s;
  logic [CHAR_W-1:0] key_s;
  logic              kpar_s;
  logic              key_evt;
  logic              done_evt;

  assign sel_s    = sync_r[SYNC_W-1 -: CH_W];
  assign creset_s = sync_r[CHAR_W+3];
  assign key_s    = sync_r[CHAR_W+2:3];
  assign kpar_s   = sync_r[2];
  assign key_evt  = sync_r[1] && !kstb_d_r;
  assign done_evt = sync_r[0] && !done_d_r;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  logic [CH_W-1:0]   cmd_ch;
  logic [WORD_W-1:0] cmd_word;
  logic              wr_dev;
  logic              wr_dsc;
  logic              tw_sel;
  logic              read_keyboard_cmd;
  logic              type_output_cmd;
  logic              dsc_tw;
  logic              top_tw;

  assign cmd_ch   = bus_wdata_i[CH_SEL_LSB +: CH_W];
  assign cmd_word = bus_wdata_i[WORD_W-1:0];
  assign wr_dev   = bus_we_i && bus_addr_i == OFS_DEV_SEL;
  assign wr_dsc   = bus_we_i && bus_addr_i == OFS_DISCONNECT;
  assign tw_sel   = wr_dev && cmd_ch == CH_W'(TW_CHAN);
  // The typewriter is always ready, so connect never waits on a test.
  assign read_keyboard_cmd      = tw_sel && cmd_word[CODE_W-1:0] == CODE_RD_KBD;
  assign type_output_cmd      = tw_sel && cmd_word[CODE_W-1:0] == CODE_TYPE_OUT;
  assign dsc_tw   = wr_dsc && cmd_ch == CH_W'(TW_CHAN);
  assign top_tw   = bus_we_i && bus_addr_i == OFS_TERM_OUT && cmd_ch == CH_W'(TW_CHAN);

  // ----------------------------------------------------------------
  // Typewriter transfer state
  // ----------------------------------------------------------------
  twc_state_t           state_r;
  logic [WC_W-1:0]      wc_r;
  logic                 il_r;
  logic                 eor_req_r;
  logic                 top_pend_r;
  logic [WORD_W-1:0]    in_word_r;
  logic                 in_valid_r;
  logic [WORD_W-1:0]    out_word_r;
  logic                 out_valid_r;
  logic [WORD_W-1:0]    pk_word;
  logic [CHAR_W-1:0]    pk_char;
  logic                 pk_any;
  logic                 pk_full;
  logic [UA_W-1:0]      ua_r [NUM_CH];
  logic [NUM_CH-1:0]    err_r;
  logic [NUM_CH-1:0]    act_v;
  logic                 tw_active;

  logic wc_done;
  logic out_load;
  logic in_deliver;
  logic in_last;
  logic dsc_flush;
  logic key_take;
  logic rate_err;
  logic par_err;
  logic tw_err_evt;
  logic out_fin;
  logic tw_term;
  logic rd_data;

  assign tw_active  = |ua_r[TW_CHAN];
  assign wc_done    = il_r && wc_r == '0;
  assign out_load   = state_r == ST_OUT_EMPTY && out_valid_r && !wc_done;
  assign out_fin    = state_r == ST_OUT_EMPTY && (wc_done || (top_pend_r && !out_valid_r));
  assign in_deliver = state_r == ST_IN && pk_full && !in_valid_r;
  assign in_last    = in_deliver && il_r && wc_r == WC_W'(1);
  assign tw_term    = out_fin || in_last;
  // A disconnect mid-word hands over the characters already typed if the holding register is empty.
  assign dsc_flush  = dsc_tw && state_r == ST_IN && pk_any && !pk_full && !in_valid_r;
  assign key_take   = state_r == ST_IN && key_evt && !pk_full;
  assign rate_err   = state_r == ST_IN && key_evt && pk_full;
  assign par_err    = key_take && !(^{kpar_s, key_s});
  assign tw_err_evt = rate_err || par_err;
  assign rd_data    = bus_re_i && bus_addr_i == OFS_DATA;

  twc_char_pack u_pack (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .clear_i   (read_keyboard_cmd || type_output_cmd || in_deliver || dsc_tw || creset_s),
    .load_i    (out_load),
    .word_i    (out_word_r),
    .put_i     (key_take),
    .char_i    (key_s),
    .take_i    (state_r == ST_OUT_SEND),
    .word_o    (pk_word),
    .char_o    (pk_char),
    .any_o     (pk_any),
    .full_o    (pk_full)
  );

  // Transfer sequencer; any disconnect path wins over normal stepping.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      state_r <= ST_IDLE;
    else if (creset_s || dsc_tw || tw_term)
      state_r <= ST_IDLE;
    else if (read_keyboard_cmd)
      state_r <= ST_IN;
    else if (type_output_cmd)
      state_r <= ST_OUT_EMPTY;
    else if (tw_sel)
      state_r <= ST_IDLE;
    else
      case (state_r)
        ST_OUT_EMPTY: if (out_load) state_r <= ST_OUT_SEND;
        ST_OUT_SEND:  state_r <= ST_OUT_WAIT;
        ST_OUT_WAIT:  if (done_evt) state_r <= pk_full ? ST_OUT_EMPTY : ST_OUT_SEND;
        default:      state_r <= state_r;
      endcase
  end

  // Word count, interlace alert, and the pending terminate-output request.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wc_r       <= RST_WC;
      il_r       <= 1'b0;
      eor_req_r  <= 1'b0;
      top_pend_r <= 1'b0;
    end
    else
    begin
      if (bus_we_i && bus_addr_i == OFS_WORD_COUNT)
        wc_r <= bus_wdata_i[WC_W-1:0];
      else if ((out_load || in_deliver) && il_r && wc_r != '0)
        wc_r <= wc_r - 1'b1;
      if (read_keyboard_cmd || type_output_cmd)
        il_r <= cmd_word[IL_BIT];
      if (bus_we_i && bus_addr_i == OFS_XFER_CTRL)
        eor_req_r <= bus_wdata_i[EOR_REQ_BIT];
      if (read_keyboard_cmd || type_output_cmd || tw_term || creset_s)
        top_pend_r <= 1'b0;
      else if (top_tw && tw_active)
        top_pend_r <= 1'b1;
    end
  end

  // Word holding registers to and from software; a new event wins over a read.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      in_word_r   <= '0;
      in_valid_r  <= 1'b0;
      out_word_r  <= '0;
      out_valid_r <= 1'b0;
    end
    else
    begin
      if (in_deliver || dsc_flush)
      begin
        in_word_r  <= pk_word;
        in_valid_r <= 1'b1;
      end
      else if (rd_data || creset_s)
        in_valid_r <= 1'b0;
      if (bus_we_i && bus_addr_i == OFS_DATA)
      begin
        out_word_r  <= bus_wdata_i[WORD_W-1:0];
        out_valid_r <= 1'b1;
      end
      else if (out_load || creset_s || type_output_cmd)
        out_valid_r <= 1'b0;
    end
  end

  // Character toward the typewriter, with odd parity added.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tw_char_o     <= CHAR_SPACE;
      tw_char_par_o <= 1'b0;
      tw_char_stb_o <= 1'b0;
    end
    else
    begin
      tw_char_stb_o <= state_r == ST_OUT_SEND;
      if (state_r == ST_OUT_SEND)
      begin
        tw_char_o     <= pk_char;
        tw_char_par_o <= ~^pk_char;
      end
    end
  end

  // Typewriter lamps follow the connect command and drop when inactive.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tw_input_lamp_o <= 1'b0;
      tw_power_o      <= 1'b0;
    end
    else if (read_keyboard_cmd || type_output_cmd)
    begin
      tw_input_lamp_o <= read_keyboard_cmd;
      tw_power_o      <= 1'b1;
    end
    else if (!tw_active)
    begin
      tw_input_lamp_o <= 1'b0;
      tw_power_o      <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel unit address, error flip-flop and lamps
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ch
      logic hit;
      assign hit      = cmd_ch == CH_W'(g);
      assign act_v[g] = |ua_r[g];

      // Nonzero unit address is the active state itself.
      always_ff @(posedge ref_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          ua_r[g] <= RST_UA;
        else if (creset_s)
          ua_r[g] <= RST_UA;
        else if (wr_dev && hit)
          ua_r[g] <= cmd_word[UA_W-1:0];
        else if ((wr_dsc && hit) || (g == TW_CHAN && tw_term))
          ua_r[g] <= RST_UA;
      end

      // An error in the same cycle as a device select is kept.
      always_ff @(posedge ref_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          err_r[g] <= 1'b0;
        else if (creset_s)
          err_r[g] <= 1'b0;
        else if (g == TW_CHAN && tw_err_evt)
          err_r[g] <= 1'b1;
        else if (wr_dev && hit)
          err_r[g] <= 1'b0;
      end

      always_ff @(posedge ref_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          active_lamp_o[g] <= 1'b0;
          error_lamp_o[g]  <= 1'b0;
        end
        else
        begin
          active_lamp_o[g] <= act_v[g];
          error_lamp_o[g]  <= err_r[g];
        end
      end
    end
  endgenerate

  // Unit address display of the switch-selected channel.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      unit_addr_disp_o <= RST_UA;
    else
      unit_addr_disp_o <= ua_r[sel_s];
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic [INT_W-1:0] int_stat_r;
  logic [INT_W-1:0] int_en_r;
  logic [INT_W-1:0] int_ev;
  logic [INT_W-1:0] int_clr;

  always_comb
  begin
    int_ev               = '0;
    int_ev[INT_EOR]      = out_fin && wc_done && eor_req_r;
    int_ev[INT_WC_ZERO]  = in_last || (out_fin && wc_done);
    int_ev[INT_ERROR]    = tw_err_evt;
    int_ev[INT_WORD_IN]  = in_deliver || dsc_flush;
    int_ev[INT_WORD_OUT] = out_load;
    int_ev[INT_CR]       = key_take && key_s == CHAR_CR;
  end

  assign int_clr = (bus_we_i && bus_addr_i == OFS_INT_CLR) ? bus_wdata_i[INT_W-1:0] : '0;

  // A new event beats a clear of the same bit.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      int_stat_r <= '0;
      int_en_r   <= RST_INT_EN;
      irq_o      <= 1'b0;
    end
    else
    begin
      int_stat_r <= (int_stat_r & ~int_clr) | int_ev;
      if (bus_we_i && bus_addr_i == OFS_INT_EN)
        int_en_r <= bus_wdata_i[INT_W-1:0];
      irq_o <= |(int_stat_r & int_en_r);
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Read data stand only in the cycle after the strobe; otherwise zero.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bus_rdata_o <= '0;
    else if (!bus_re_i)
      bus_rdata_o <= '0;
    else
      case (bus_addr_i)
        OFS_DATA:       bus_rdata_o <= {{(DATA_W-WORD_W){1'b0}}, in_word_r};
        OFS_INT_STAT:   bus_rdata_o <= {{(DATA_W-INT_W){1'b0}}, int_stat_r};
        OFS_INT_EN:     bus_rdata_o <= {{(DATA_W-INT_W){1'b0}}, int_en_r};
        OFS_WORD_COUNT: bus_rdata_o <= {{(DATA_W-WC_W){1'b0}}, wc_r};
        OFS_XFER_CTRL:  bus_rdata_o <= {30'h0, il_r, eor_req_r};
        OFS_CHAN_STAT:  bus_rdata_o <= {10'h0, state_r, out_valid_r, in_valid_r, 1'b1, err_r, act_v};
        default:
          if (bus_addr_i[7:5] == OFS_CAT_BASE[7:5] && bus_addr_i[1:0] == 2'b00)
            bus_rdata_o <= {31'h0, !act_v[bus_addr_i[4:2]]};
          else
            bus_rdata_o <= '0;
      endcase
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_lamp_follows;
    $rose(act_v[TW_CHAN]) |=> active_lamp_o[TW_CHAN] ##1 (active_lamp_o[TW_CHAN] == $past(act_v[TW_CHAN]));
  endproperty
  a_lamp_follows: assert property (p_lamp_follows) else $error("active lamp lags");

  property p_err_clear;
    (tw_sel && !tw_err_evt && !creset_s) |=> ##1 !error_lamp_o[TW_CHAN];
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error lamp not cleared");

  property p_creset;
    creset_s |=> (err_r == '0) && !act_v[TW_CHAN];
  endproperty
  a_creset: assert property (p_creset) else $error("console reset left state");

  property p_rkb;
    (read_keyboard_cmd && !creset_s) |=> (state_r == ST_IN) && tw_active && tw_input_lamp_o;
  endproperty
  a_rkb: assert property (p_rkb) else $error("keyboard connect failed");

  property p_typ;
    (type_output_cmd && !creset_s) |=> (state_r == ST_OUT_EMPTY) && tw_power_o && !tw_input_lamp_o;
  endproperty
  a_typ: assert property (p_typ) else $error("type connect failed");

  property p_cat;
    (bus_re_i && bus_addr_i == OFS_CAT_BASE && TW_CHAN == 0) |=> bus_rdata_o[0] == !$past(tw_active);
  endproperty
  a_cat: assert property (p_cat) else $error("active test wrong");

  property p_par_err;
    (par_err && !creset_s) |=> err_r[TW_CHAN] ##1 error_lamp_o[TW_CHAN];
  endproperty
  a_par_err: assert property (p_par_err) else $error("parity error lost");

  property p_il;
    (read_keyboard_cmd || type_output_cmd) |=> il_r == $past(bus_wdata_i[IL_BIT]);
  endproperty
  a_il: assert property (p_il) else $error("interlace alert not taken");

  property p_out_end;
    (out_fin && wc_done && eor_req_r && !creset_s) |=> !tw_active && int_stat_r[INT_EOR] && (state_r == ST_IDLE);
  endproperty
  a_out_end: assert property (p_out_end) else $error("output end wrong");

  property p_in_last;
    (in_last && !creset_s) |=> !tw_active && in_valid_r && (state_r == ST_IDLE);
  endproperty
  a_in_last: assert property (p_in_last) else $error("input end wrong");

  property p_active;
    (state_r != ST_IDLE) |-> tw_active;
  endproperty
  a_active: assert property (p_active) else $error("busy while inactive");

endmodule
`default_nettype wire

// ---- hdl/twc_char_pack.sv ----
`timescale 1ns/1ps
`default_nettype none
// Packs characters into a word or unpacks a word into characters, first
// character in the most significant slot; unused slots hold the pad code.
module twc_char_pack
  import twc_pkg::*;
#(
  parameter int                CW  = CHAR_W,
  parameter int                NC  = CHARS_PER_WORD,
  parameter logic [CHAR_W-1:0] PAD = CHAR_SPACE
)
(
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             clear_i,
  input  wire logic             load_i,
  input  wire logic [NC*CW-1:0] word_i,
  input  wire logic             put_i,
  input  wire logic [CW-1:0]    char_i,
  input  wire logic             take_i,
  output logic      [NC*CW-1:0] word_o,
  output logic      [CW-1:0]    char_o,
  output logic                  any_o,
  output logic                  full_o
);

  localparam int CNT_W = $clog2(NC + 1);
  localparam int IDX_W = $clog2(NC);

  logic [CNT_W-1:0] cnt_r;
  logic [CW-1:0]    slot_r [NC];

  // Slot pointer; it stops at a full word so a stray strobe cannot wrap it.
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cnt_r <= '0;
    else if (clear_i || load_i)
      cnt_r <= '0;
    else if ((put_i || take_i) && !full_o)
      cnt_r <= cnt_r + 1'b1;
  end

  genvar g;
  generate
    for (g = 0; g < NC; g++)
    begin : g_slot
      // A cleared slot holds the pad so a partial word is padded for free.
      always_ff @(posedge ref_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          slot_r[g] <= PAD;
        else if (clear_i)
          slot_r[g] <= PAD;
        else if (load_i)
          slot_r[g] <= word_i[(NC-1-g)*CW +: CW];
        else if (put_i && cnt_r == CNT_W'(g))
          slot_r[g] <= char_i;
      end
      assign word_o[(NC-1-g)*CW +: CW] = slot_r[g];
    end
  endgenerate

  // The current slot is the next one to send.
  // The pointer is one bit wider than a slot index; a full word never indexes.
  assign char_o = full_o ? PAD : slot_r[IDX_W'(cnt_r)];
  assign full_o = (cnt_r == CNT_W'(NC));
  assign any_o  = (cnt_r != '0);

endmodule
`default_nettype wire

// ---- shared/twc_pkg.sv ----
`default_nettype none
package twc_pkg;

  // ----------------------------------------------------------------
  // Sizes of the channel and its data path
  // ----------------------------------------------------------------
  localparam int NUM_CH         = 8;
  localparam int CH_W           = 3;
  localparam int UA_W           = 6;
  localparam int WORD_W         = 24;
  localparam int CHAR_W         = 6;
  localparam int CHARS_PER_WORD = 4;
  localparam int WC_W           = 9;
  localparam int ADDR_W         = 8;
  localparam int DATA_W         = 32;
  localparam int CODE_W         = 14;

  // ----------------------------------------------------------------
  // Command word fields
  // ----------------------------------------------------------------
  // The interlace alert is bit 9 counted from the most significant end.
  localparam int IL_DOC_BIT  = 9;
  localparam int IL_BIT      = WORD_W - 1 - IL_DOC_BIT;
  localparam int CH_SEL_LSB  = 24;
  localparam int EOR_REQ_BIT = 0;
  localparam logic [CODE_W-1:0] CODE_RD_KBD   = 14'h0581;
  localparam logic [CODE_W-1:0] CODE_TYPE_OUT = 14'h05a1;

  // Character codes on the typewriter path.
  localparam logic [CHAR_W-1:0] CHAR_CR    = 6'h2a;
  localparam logic [CHAR_W-1:0] CHAR_SPACE = 6'h0a;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_DEV_SEL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DISCONNECT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TERM_OUT   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_XFER_CTRL  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_WORD_COUNT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_DATA       = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_INT_STAT   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_INT_CLR    = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_INT_EN     = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_CHAN_STAT  = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_CAT_BASE   = 8'h40;

  // ----------------------------------------------------------------
  // Interrupt status bits and reset values
  // ----------------------------------------------------------------
  localparam int INT_W       = 6;
  localparam int INT_EOR     = 0;
  localparam int INT_WC_ZERO = 1;
  localparam int INT_ERROR   = 2;
  localparam int INT_WORD_IN = 3;
  localparam int INT_WORD_OUT= 4;
  localparam int INT_CR      = 5;
  localparam logic [INT_W-1:0] RST_INT_EN = 6'h00;
  localparam logic [UA_W-1:0]  RST_UA     = 6'h00;
  localparam logic [WC_W-1:0]  RST_WC     = 9'h000;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_IN        = 3'b001,
    ST_OUT_EMPTY = 3'b010,
    ST_OUT_SEND  = 3'b011,
    ST_OUT_WAIT  = 3'b100
  } twc_state_t;

endpackage
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import twc_pkg::*;
;
  logic ref_clk_i, rst_n_i, bus_we_i, bus_re_i, console_reset_i, irq_o;
  logic tw_key_par_i, tw_key_stb_i, tw_done_i, tw_char_par_o, tw_char_stb_o;
  logic tw_input_lamp_o, tw_power_o;
  logic [ADDR_W-1:0] bus_addr_i;
  logic [DATA_W-1:0] bus_wdata_i, bus_rdata_o;
  logic [CH_W-1:0]   chan_sel_i;
  logic [CHAR_W-1:0] tw_key_i, tw_char_o;
  logic [NUM_CH-1:0] active_lamp_o, error_lamp_o;
  logic [UA_W-1:0]   unit_addr_disp_o;
  int bad_count, comparisons;
  localparam logic [23:0] OW = {CHAR_CR, 6'h21, CHAR_SPACE, 6'h3f};
  twc_chan_ctrl DUT (.ref_clk_i, .rst_n_i, .bus_addr_i, .bus_wdata_i, .bus_we_i, .bus_re_i,
    .bus_rdata_o, .irq_o, .chan_sel_i, .console_reset_i, .tw_key_i, .tw_key_par_i,
    .tw_key_stb_i, .tw_done_i, .tw_char_o, .tw_char_par_o, .tw_char_stb_o, .tw_input_lamp_o,
    .tw_power_o, .active_lamp_o, .error_lamp_o, .unit_addr_disp_o);
  twc_tw_model tw (.ref_clk_i, .tw_char_i(tw_char_o), .tw_char_stb_i(tw_char_stb_o),
    .tw_key_o(tw_key_i), .tw_key_par_o(tw_key_par_i), .tw_key_stb_o(tw_key_stb_i),
    .tw_done_o(tw_done_i));
  // Free-running clock.
  initial
  begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bus tasks are entered just after a rising edge.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    bus_addr_i <= a;
    bus_wdata_i <= d;
    bus_we_i <= 1'b1;
    @(posedge ref_clk_i);
    bus_we_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    bus_addr_i <= a;
    bus_re_i <= 1'b1;
    @(posedge ref_clk_i);
    bus_re_i <= 1'b0;
    @(posedge ref_clk_i);
    d = bus_rdata_o;
  endtask
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic t_reset();
    chk(tw_char_o, CHAR_SPACE);
    rdc(OFS_CHAN_STAT, 32'h0001_0000);
    rdc(8'hfc, 32'h0);
  endtask
  // Interlaced output of one word ends by itself and raises end of record.
  task automatic t_type();
    logic [DATA_W-1:0] d;
    wr(OFS_WORD_COUNT, 32'h1);
    wr(OFS_XFER_CTRL, 32'h1);
    wr(OFS_INT_EN, 32'h1);
    wr(OFS_DEV_SEL, 32'h4000 | CODE_TYPE_OUT);
    repeat (2) @(posedge ref_clk_i);
    chk(tw_power_o, 1'b1);
    chk(active_lamp_o, 8'h01);
    chk(unit_addr_disp_o, 6'h21);
    rdc(OFS_CAT_BASE, 32'h0);
    wr(OFS_DATA, OW);
    for (int i = 0; i < 400 && tw.printed.size() < 4; i++) @(posedge ref_clk_i);
    for (int i = 0; i < 4; i++) chk(tw.printed[i], OW[23-6*i -: 6]);
    d = 0;
    for (int i = 0; i < 40 && d !== 1; i++) rd(OFS_CAT_BASE, d);
    chk(d, 32'h1);
    rdc(OFS_INT_STAT, 32'h13);
    chk(irq_o, 1'b1);
    chk(active_lamp_o, 8'h00);
    wr(OFS_INT_EN, 32'h0);
    repeat (2) @(posedge ref_clk_i);
    chk(irq_o, 1'b0);
    wr(OFS_INT_CLR, 32'h3f);
    rdc(OFS_INT_STAT, 32'h0);
  endtask
  // Keyboard word with a parity slip, then select and console reset clear the lamp.
  task automatic t_key();
    repeat (20) @(posedge ref_clk_i);
    wr(OFS_DEV_SEL, CODE_RD_KBD);
    @(posedge ref_clk_i);
    chk(tw_input_lamp_o, 1'b1);
    for (int i = 0; i < 4; i++) tw.key(24'h46a2bc >> (18 - 6 * i), i == 1);
    rdc(OFS_DATA, 32'h46a2bc);
    chk(error_lamp_o, 8'h01);
    wr(OFS_DISCONNECT, 32'h0);
    rdc(OFS_CAT_BASE, 32'h1);
    wr(OFS_DEV_SEL, CODE_RD_KBD);
    repeat (2) @(posedge ref_clk_i);
    chk(error_lamp_o, 8'h00);
    tw.key(6'h05, 1'b1);
    chk(error_lamp_o, 8'h01);
    console_reset_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    chk(error_lamp_o, 8'h00);
    console_reset_i <= 1'b0;
  endtask
  // Terminated single-word output, interlaced one-word input, channel 3 shown.
  task automatic t_more();
    logic [DATA_W-1:0] d;
    // The console reset is still in the synchroniser for a few cycles.
    repeat (4) @(posedge ref_clk_i);
    wr(OFS_DEV_SEL, CODE_TYPE_OUT);
    wr(OFS_DATA, OW);
    wr(OFS_TERM_OUT, 32'h0);
    for (int i = 0; i < 400 && tw.printed.size() < 8; i++) @(posedge ref_clk_i);
    chk(tw.printed[7], 6'h3f);
    chk(^{tw_char_par_o, tw_char_o}, 1'b1);
    d = 0;
    for (int i = 0; i < 40 && d !== 1; i++) rd(OFS_CAT_BASE, d);
    chk(d, 32'h1);
    wr(OFS_INT_CLR, 32'h3f);
    wr(OFS_WORD_COUNT, 32'h1);
    wr(OFS_DEV_SEL, 32'h4000 | CODE_RD_KBD);
    for (int i = 0; i < 4; i++) tw.key(6'h21, 1'b0);
    rdc(OFS_CAT_BASE, 32'h1);
    rdc(OFS_INT_STAT, 32'h0a);
    wr(OFS_DEV_SEL, 32'h0300_002a);
    chan_sel_i <= 3'h3;
    repeat (4) @(posedge ref_clk_i);
    chk(unit_addr_disp_o, 6'h2a);
    chk(active_lamp_o, 8'h08);
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    {rst_n_i, bus_we_i, bus_re_i, console_reset_i, bus_addr_i, bus_wdata_i, chan_sel_i} = '0;
    repeat (12) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    t_reset();
    t_type();
    t_key();
    t_more();
    end_of_test();
  end
  // A hang counts as a mismatch.
  initial
  begin
    repeat (30000) @(posedge ref_clk_i);
    bad_count++;
    end_of_test();
  end
endmodule
`default_nettype wire

// ---- test/twc_tw_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module twc_tw_model
  import twc_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic [CHAR_W-1:0] tw_char_i,
  input  wire logic              tw_char_stb_i,
  output logic      [CHAR_W-1:0] tw_key_o,
  output logic                   tw_key_par_o,
  output logic                   tw_key_stb_o,
  output logic                   tw_done_o
);
  logic [CHAR_W-1:0] printed [$];
  initial
  begin
    {tw_key_o, tw_key_par_o, tw_key_stb_o, tw_done_o} = '0;
  end
  // Print each strobed character, then report done some cycles later.
  always @(posedge ref_clk_i)
  begin
    if (tw_char_stb_i)
    begin
      printed.push_back(tw_char_i);
      repeat (4) @(posedge ref_clk_i);
      tw_done_o <= 1'b1;
      repeat (2) @(posedge ref_clk_i);
      tw_done_o <= 1'b0;
    end
  end
  // One keystroke; the key lines show the inverse once released.
  task automatic key(input logic [CHAR_W-1:0] c, input logic bad);
    tw_key_o <= c;
    tw_key_par_o <= ~^c ^ bad;
    repeat (2) @(posedge ref_clk_i);
    tw_key_stb_o <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    tw_key_stb_o <= 1'b0;
    tw_key_o <= ~c;
    repeat (6) @(posedge ref_clk_i);
  endtask
endmodule
`default_nettype wire
